// >>> win_chk.sv
// port assertions for the region-one window
`timescale 1ns/100ps
`default_nettype none
module win_chk
	import window_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire host_req_t host_req,
	input wire logic [DATA_W-1:0] window_data_register,
	input wire logic host_rd_done,
	input wire logic host_busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic take;
	logic wtake;
	assign take = host_req.rd && !host_busy;
	assign wtake = host_req.wr && !host_req.rd && !host_busy;
	bus_ready_a: assert property (hreadyout) else $error("not ready");
	bus_okay_a: assert property (hresp == HRESP_OKAY) else $error("not okay");
	rd_answer_a: assert property (take |=> host_busy != host_rd_done) else $error("no answer");
	busy_done_a: assert property (host_busy |=> host_rd_done && !host_busy) else $error("no done");
	// a refused read taken in the done cycle legally answers again at once
	done_pulse_a: assert property (host_rd_done && !take |=> !host_rd_done)
		else $error("long done");
	refused_keep_a: assert property (
		take ##1 host_rd_done |-> $stable(window_data_register))
		else $error("data moved");
	wr_bytes_a: assert property (
		wtake && host_req.be == 4'hf |=> window_data_register == $past(host_req.wdata))
		else $error("bytes lost");
	wr_quiet_a: assert property (wtake |=> !host_busy && !host_rd_done) else $error("write busy");
endmodule
bind window_region_one win_chk win_chk_inst (.*);
`default_nettype wire

// >>> win_host.sv
// host side driver of the window port
`timescale 1ns/100ps
`default_nettype none
module win_host
	import window_pkg::*;
(
	input wire logic sys_clk,
	output logic [WIN_AW-1:0] window_address,
	output var host_req_t host_req
);
	initial begin
		window_address = '0;
		host_req = '0;
	end
	// idle two edges after each pulse so an accepted read never meets busy
	task automatic go(input logic [15:0] a, input logic r, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge sys_clk);
		window_address <= a;
		host_req <= '{r, !r, be, d};
		@(posedge sys_clk);
		host_req <= '{1'b0, 1'b0, 4'h0, ~d};
		repeat (2) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// >>> window_pkg.sv
// shared constants and types for the region-one host memory window
`default_nettype none
package window_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned MEM_AW = 10;
	localparam int unsigned WIN_AW = 16;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_BASE0 = 12'h0104;
	localparam logic [11:0] IDX_RDCEIL0 = 12'h0108;
	localparam logic [11:0] IDX_WRCEIL0 = 12'h010a;
	localparam logic [11:0] IDX_BASE1 = 12'h010c;
	localparam logic [11:0] IDX_RDCEIL1 = 12'h0110;
	localparam logic [11:0] IDX_WRCEIL1 = 12'h0112;
	localparam logic [11:0] IDX_WINDATA = 12'h0118;
	localparam logic [11:0] IDX_STATUS = 12'h011a;
	localparam logic [31:0] BASE_RST = 32'h0000_0000;
	localparam logic [15:0] CEIL_RST = 16'h0000;
	localparam logic [31:0] BASE_MASK = 32'hffff_fffc;
	localparam logic [15:0] CEIL_MASK = 16'h7ffc;
	localparam int unsigned REGION_BIT = 15;
	localparam int unsigned WORD_LSB = 2;
	localparam int unsigned WORD_MSB = 14;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] be;
		logic [DATA_W-1:0] wdata;
	} host_req_t;

	typedef struct packed {
		logic [31:0] base;
		logic [15:0] rd_ceil;
		logic [15:0] wr_ceil;
	} region_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01
	} win_state_t;
endpackage
`default_nettype wire

// >>> window_region_one.sv
// host memory window: region select, relocation, read/write ceilings, AHB-Lite registers
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module window_region_one
	import window_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [WIN_AW-1:0] window_address,
	input wire host_req_t host_req,
	output logic [DATA_W-1:0] window_data_register,
	output logic host_rd_done,
	output logic host_busy
);
	region_t region0_q, region1_q;
	logic [31:0] hrdata_q;
	logic wr_pend_q;
	logic [11:0] wr_idx_q;
	logic [DATA_W-1:0] win_data_q;
	win_state_t state_q;
	logic rd_refused_q, wr_refused_q, last_region_q;
	logic rd_done_q;

	// registers sit in the low 16 KB of the bus, one aligned word each
	function automatic logic reg_space(input logic [31:0] a);
		return a[31:14] == 18'h0_0000 && a[1:0] == 2'b00;
	endfunction

	// only word bits compare; bit 15 and byte bits of a ceiling never matter
	function automatic logic below_ceiling(input logic [WIN_AW-1:0] a, input logic [15:0] c);
		return a[WORD_MSB:WORD_LSB] < c[WORD_MSB:WORD_LSB];
	endfunction

	// ahb-lite slave: zero wait states, always OKAY
	logic addr_phase;
	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdata_q;

	// word index of the register; the byte address is four times it
	logic [11:0] acc_idx;
	assign acc_idx = haddr[13:2];

	// status: busy, region, write refused, read refused in bit 0
	logic [31:0] status_word;
	assign status_word = {28'h000_0000, host_busy, last_region_q, wr_refused_q, rd_refused_q};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (reg_space(haddr)) begin
			case (acc_idx)
				IDX_BASE0: rd_mux = region0_q.base;
				IDX_RDCEIL0: rd_mux = {16'h0000, region0_q.rd_ceil};
				IDX_WRCEIL0: rd_mux = {16'h0000, region0_q.wr_ceil};
				IDX_BASE1: rd_mux = region1_q.base;
				IDX_RDCEIL1: rd_mux = {16'h0000, region1_q.rd_ceil};
				IDX_WRCEIL1: rd_mux = {16'h0000, region1_q.wr_ceil};
				IDX_WINDATA: rd_mux = win_data_q;
				IDX_STATUS: rd_mux = status_word;
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// read data registered in the address phase; a read right after a write
	// to the same register returns the old value
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hrdata_q <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata_q <= rd_mux;
		end
	end

	// write data arrives one cycle after its address phase; unaligned writes dropped
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 12'h000;
		end else begin
			wr_pend_q <= addr_phase && hwrite && reg_space(haddr);
			if (addr_phase) begin
				wr_idx_q <= acc_idx;
			end
		end
	end

	// reserved bits are masked on write so they always read back as zero
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			region0_q <= '{base: BASE_RST, rd_ceil: CEIL_RST, wr_ceil: CEIL_RST};
			region1_q <= '{base: BASE_RST, rd_ceil: CEIL_RST, wr_ceil: CEIL_RST};
		end else if (wr_pend_q) begin
			case (wr_idx_q)
				IDX_BASE0: region0_q.base <= hwdata & BASE_MASK;
				IDX_RDCEIL0: region0_q.rd_ceil <= hwdata[15:0] & CEIL_MASK;
				IDX_WRCEIL0: region0_q.wr_ceil <= hwdata[15:0] & CEIL_MASK;
				IDX_BASE1: region1_q.base <= hwdata & BASE_MASK;
				IDX_RDCEIL1: region1_q.rd_ceil <= hwdata[15:0] & CEIL_MASK;
				IDX_WRCEIL1: region1_q.wr_ceil <= hwdata[15:0] & CEIL_MASK;
				default: ;
			endcase
		end
	end

	// window access path
	region_t sel;
	logic sel_one;
	assign sel_one = window_address[REGION_BIT];
	assign sel = sel_one ? region1_q : region0_q;

	// no carry check: a sum past the top of the space wraps silently
	logic [31:0] target;
	assign target = sel.base + {16'h0000, 1'b0, window_address[WORD_MSB:0]};

	logic rd_ok, wr_ok, take_rd, take_wr;
	assign rd_ok = below_ceiling(window_address, sel.rd_ceil);
	assign wr_ok = below_ceiling(window_address, sel.wr_ceil);
	// requests while busy are dropped, not queued; a read wins over a write
	assign take_rd = host_req.rd && state_q == ST_IDLE;
	assign take_wr = host_req.wr && !host_req.rd && state_q == ST_IDLE;
	assign host_busy = state_q != ST_IDLE;
	assign host_rd_done = rd_done_q;
	assign window_data_register = win_data_q;

	logic mem_re, mem_we;
	logic [DATA_W-1:0] mem_rdata;
	assign mem_re = take_rd && rd_ok;
	assign mem_we = take_wr && wr_ok;

	// memory holds 1024 words; target bits above them are ignored
	window_sram u_sram (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.re(mem_re),
		.we(mem_we),
		.be(host_req.be),
		.addr(target[MEM_AW+1:WORD_LSB]),
		.wdata(host_req.wdata),
		.rdata_q(mem_rdata)
	);

	// a read accepted below the ceiling waits one cycle for the memory
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: state_q <= mem_re ? ST_READ : ST_IDLE;
				ST_READ: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			win_data_q <= '0;
		end else if (state_q == ST_READ) begin
			win_data_q <= mem_rdata;
		// the data register takes the bytes even when the memory refuses them
		end else if (take_wr) begin
			for (int i = 0; i < 4; i++) begin
				if (host_req.be[i]) begin
					win_data_q[i*8 +: 8] <= host_req.wdata[i*8 +: 8];
				end
			end
		end
	end

	// one-cycle pulse: read loaded from memory or refused at the ceiling
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_done_q <= 1'b0;
		end else begin
			rd_done_q <= (state_q == ST_READ) || (take_rd && !rd_ok);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_refused_q <= 1'b0;
			wr_refused_q <= 1'b0;
		end else begin
			if (take_rd) begin
				rd_refused_q <= !rd_ok;
			end
			if (take_wr) begin
				wr_refused_q <= !wr_ok;
			end
		end
	end

	// region of the last accepted request, kept for software diagnosis
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			last_region_q <= 1'b0;
		end else if (take_rd || take_wr) begin
			last_region_q <= sel_one;
		end
	end
endmodule
`default_nettype wire

// >>> window_region_one_tb_top.sv
// self-checking bench for the region-one window
`timescale 1ns/100ps
`default_nettype none
module window_region_one_tb_top
	import window_pkg::*;
;
	logic sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, wdr, d, m[5];
	logic [1:0] htrans = '0;
	logic hreadyout, hresp, rd_done, busy;
	logic [15:0] wa;
	host_req_t rq;
	logic [31:0] exp_q[$];
	int n_fail = 0, n_compared = 0;
	always #2 sys_clk = ~sys_clk;
	window_region_one window_region_one_inst (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.window_address(wa), .host_req(rq), .window_data_register(wdr),
		.host_rd_done(rd_done), .host_busy(busy));
	win_host win_host_inst (.sys_clk(sys_clk), .window_address(wa), .host_req(rq));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] v);
		@(posedge sys_clk);
		hsel <= 1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge sys_clk); while (hreadyout !== 1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= w ? v : ~v;
		do @(posedge sys_clk); while (hreadyout !== 1);
		if (!w) chk("register", v, hrdata);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		win_host_inst.go(a, 1, 4'h0, 32'h0000_0000);
	endtask
	// sampled mid-cycle so the loading edge has settled
	always @(negedge sys_clk) begin
		if (rd_done === 1) begin
			chk("window data", exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxx_xxxx, wdr);
		end
	end
	initial begin
		void'($urandom(3057));
		repeat (4) @(posedge sys_clk);
		nrst <= 1;
		ahb(32'h0000_0430, 0, 32'h0000_0000);
		ahb(32'h0000_0440, 0, 32'h0000_0000);
		ahb(32'h0000_0448, 0, 32'h0000_0000);
		ahb(32'h0000_0ffc, 0, 32'h0000_0000);
		ahb(32'h0000_0430, 1, 32'h0000_0103);
		ahb(32'h0000_0430, 0, 32'h0000_0100);
		ahb(32'h0000_0440, 1, 32'h0000_8023);
		ahb(32'h0000_0440, 0, 32'h0000_0020);
		ahb(32'h0000_0448, 1, 32'h0000_0014);
		for (int i = 0; i < 5; i++) begin
			m[i] = $urandom;
			win_host_inst.go(16'h8000 | 16'(i * 4), 0, 4'hf, m[i]);
		end
		ahb(32'h0000_0448, 1, 32'h0000_8013);
		ahb(32'h0000_0448, 0, 32'h0000_0010);
		d = $urandom;
		win_host_inst.go(16'h8010, 0, 4'hf, d);
		ahb(32'h0000_0468, 0, 32'h0000_0006);
		win_host_inst.go(16'h8000, 0, 4'h3, d);
		m[0][15:0] = d[15:0];
		for (int i = 0; i < 5; i++) rd(16'h8000 | 16'(i * 4), m[i]);
		rd(16'h8020, m[4]);
		ahb(32'h0000_0468, 0, 32'h0000_0005);
		ahb(32'h0000_0410, 1, 32'h0000_0104);
		ahb(32'h0000_0420, 1, 32'h0000_7ffc);
		rd(16'h0000, m[1]);
		ahb(32'h0000_0420, 0, 32'h0000_7ffc);
		ahb(32'h0000_0460, 0, m[1]);
		chk("reads pending", 32'h0000_0000, 32'(exp_q.size()));
		give_verdict;
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_fail++;
		give_verdict;
	end
endmodule
`default_nettype wire

// >>> window_sram.sv
// internal shared memory with byte write enables and registered read data
`timescale 1ns/100ps
`default_nettype none
module window_sram
	import window_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic re,
	input wire logic we,
	input wire logic [3:0] be,
	input wire logic [MEM_AW-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic [DATA_W-1:0] rdata_q
);
	logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (we && be[i]) begin
				mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (re) begin
			rdata_q <= mem[addr];
		end
	end
endmodule
`default_nettype wire
